// *** dv/tpio_pins_model.sv ***
// external pins: driven pin follows the block, floating pin follows the board
`timescale 1ns/10ps
module tpio_pins_model (
	// block side
	input wire logic [6:0] firstOut,
	input wire logic [6:0] firstOe,
	input wire logic [6:0] secondOut,
	input wire logic [6:0] secondOe,
	input wire logic [1:0] thirdOut,
	input wire logic [1:0] thirdOe,
	// board side levels
	input wire logic [6:0] firstExt,
	input wire logic [6:0] secondExt,
	input wire logic [1:0] thirdExt,
	// resolved levels
	output logic [6:0] firstPin,
	output logic [6:0] secondPin,
	output logic [1:0] thirdPin
);
	assign firstPin = (firstOe & firstOut) | (~firstOe & firstExt);
	assign secondPin = (secondOe & secondOut) | (~secondOe & secondExt);
	assign thirdPin = (thirdOe & thirdOut) | (~thirdOe & thirdExt);
endmodule : tpio_pins_model

// *** dv/tpio_top_bench.sv ***
// self-checking bench for the parallel io block
`timescale 1ns/10ps
module tpio_top_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wbCyc = 1'b0;
	logic wbStb = 1'b0;
	logic wbWe = 1'b0;
	logic [7:0] wbAdr = 8'h00;
	logic [3:0] wbSel = 4'h0;
	logic [31:0] wbDatI = 32'h0;
	logic [31:0] wbDatO;
	logic wbAck;
	logic [6:0] fOut, fOe, fPin, sOut, sOe, sPin;
	logic [1:0] tOut, tOe, tPin;
	logic [6:0] fExt = 7'h0a;
	logic [6:0] sExt = 7'h50;
	logic [1:0] tExt = 2'h2;
	logic faultOne, faultFour;
	int errorCnt = 0;
	int totalChecks = 0;
	logic [3:0] selUse = 4'h1;
	always #2 clk = ~clk;
	tpio_top #(.ADR_W(8)) i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck), .firstPinIn(fPin), .firstPinOut(fOut),
		.firstPinOe(fOe), .secondPinIn(sPin), .secondPinOut(sOut), .secondPinOe(sOe),
		.thirdPinIn(tPin), .thirdPinOut(tOut), .thirdPinOe(tOe),
		.motorFaultInputOne(faultOne), .motorFaultInputFour(faultFour));
	tpio_pins_model i_pins (.firstOut(fOut), .firstOe(fOe), .secondOut(sOut), .secondOe(sOe),
		.thirdOut(tOut), .thirdOe(tOe), .firstExt(fExt), .secondExt(sExt), .thirdExt(tExt),
		.firstPin(fPin), .secondPin(sPin), .thirdPin(tPin));
	// ----------------------------------------------------------------
	// bus and compare tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		totalChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbSel <= selUse;
		wbDatI <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (wbAck !== 1'b1);
		check("ack cycles", 32'h2, n);
		q = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		xfer(a, 1'b1, d, q);
	endtask : wr
	task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		xfer(a, 1'b0, 8'h00, q);
		check(what, exp, q);
	endtask : rdChk
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic testFirst;
		rdChk("first dir reset", 8'h10, 32'h0);
		rdChk("second dir reset", 8'h14, 32'h0);
		rdChk("third dir reset", 8'h18, 32'h0);
		wr(8'h00, 8'hd5);
		wr(8'h10, 8'h70);
		repeat (6) @(posedge clk);
		check("first oe", 32'h70, {25'h0, fOe});
		check("first out", 32'h55, {25'h0, fOut});
		rdChk("first mixed read", 8'h00, 32'h5a);
		wr(8'h00, 8'hff);
		rdChk("first after write", 8'h00, 32'h7a);
		$display("test first done");
	endtask : testFirst
	task automatic testSecond;
		wr(8'h04, 8'h33);
		wr(8'h14, 8'h0f);
		rdChk("second dir", 8'h14, 32'h0f);
		rdChk("second mixed read", 8'h04, 32'h53);
		check("second oe", 32'h0f, {25'h0, sOe});
		check("second out", 32'h33, {25'h0, sOut});
		$display("test second done");
	endtask : testSecond
	task automatic testThird;
		wr(8'h08, 8'hff);
		wr(8'h18, 8'hfd);
		rdChk("third dir", 8'h18, 32'h01);
		rdChk("third mixed read", 8'h08, 32'h03);
		repeat (4) @(posedge clk);
		check("third oe", 32'h1, {30'h0, tOe});
		check("fault one off", 32'h0, {31'h0, faultOne});
		check("fault four mirror", 32'h1, {31'h0, faultFour});
		check("third out", 32'h3, {30'h0, tOut});
		wr(8'h18, 8'h00);
		tExt <= 2'h3;
		repeat (8) @(posedge clk);
		check("fault one back", 32'h1, {31'h0, faultOne});
		$display("test third done");
	endtask : testThird
	task automatic testHoles;
		wr(8'h0c, 8'hff);
		rdChk("hole read", 8'h0c, 32'h0);
		rdChk("index seven", 8'h1c, 32'h0);
		wr(8'h20, 8'h00);
		rdChk("high address", 8'h20, 32'h0);
		selUse = 4'h0;
		wr(8'h00, 8'h00);
		selUse = 4'h1;
		rdChk("latch kept", 8'h00, 32'h7a);
		$display("test holes done");
	endtask : testHoles
	task automatic testSync;
		@(posedge clk);
		fExt <= 7'h05;
		rdChk("pin not yet seen", 8'h00, 32'h7a);
		repeat (6) @(posedge clk);
		rdChk("pin seen", 8'h00, 32'h75);
		$display("test sync done");
	endtask : testSync
	task automatic testReset;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		check("latch over reset", 32'h7f, {25'h0, fOut});
		check("oe after reset", 32'h0, {25'h0, fOe});
		rdChk("all pins read", 8'h00, 32'h05);
		$display("test reset done");
	endtask : testReset
	task close_out;
		$display("checks %0d mismatches %0d", totalChecks, errorCnt);
		if (errorCnt == 0 && totalChecks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		testFirst();
		testSecond();
		testThird();
		testHoles();
		testSync();
		testReset();
		close_out();
	end
	initial begin
		repeat (5000) @(posedge clk);
		errorCnt++;
		close_out();
	end
endmodule : tpio_top_bench

// *** dv/tpio_top_monitor.sv ***
// bus and pin checker for the parallel io block
`timescale 1ns/10ps
module tpio_top_monitor #(
	parameter int ADR_W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [tpio_pkg::SEL_W-1:0] wb_sel_i,
	input wire logic [tpio_pkg::DATA_W-1:0] wb_dat_i,
	input wire logic [tpio_pkg::DATA_W-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	// pins and fault lines
	input wire logic [tpio_pkg::FIRST_W-1:0] firstPinOut,
	input wire logic [tpio_pkg::FIRST_W-1:0] firstPinOe,
	input wire logic [tpio_pkg::SECOND_W-1:0] secondPinOe,
	input wire logic [tpio_pkg::THIRD_W-1:0] thirdPinOe,
	input wire logic motorFaultInputOne,
	input wire logic motorFaultInputFour
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic wrAck;
	logic rdAck;
	assign wrAck = wb_ack_o && wb_we_i && wb_sel_i[0];
	assign rdAck = wb_ack_o && !wb_we_i;
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_ackNext; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	property p_ackPulse; wb_ack_o |=> !wb_ack_o; endproperty
	property p_dirReset;
		$rose(rst_n) |-> firstPinOe == 7'h00 && secondPinOe == 7'h00 && thirdPinOe == 2'h0;
	endproperty
	property p_dirWrite; wrAck && wb_adr_i == 8'h10 |=> firstPinOe == $past(wb_dat_i[6:0]); endproperty
	property p_latchWrite;
		wrAck && wb_adr_i == 8'h00 |=> firstPinOut == $past(wb_dat_i[6:0]);
	endproperty
	property p_readUpper; wb_ack_o |-> wb_dat_o[31:7] == 25'h0; endproperty
	property p_unimplRead; rdAck && wb_adr_i[4:2] == 3'h3 |-> wb_dat_o == 32'h0; endproperty
	property p_thirdUpper; rdAck && wb_adr_i == 8'h08 |-> wb_dat_o[31:2] == 30'h0; endproperty
	property p_outRead;
		rdAck && wb_adr_i == 8'h00 |-> (wb_dat_o[6:0] & firstPinOe) == (firstPinOut & firstPinOe);
	endproperty
	property p_faultOne; thirdPinOe[0] [*2] |-> !motorFaultInputOne; endproperty
	property p_faultFour; thirdPinOe[1] [*2] |-> !motorFaultInputFour; endproperty
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_ackNext: assert property (p_ackNext) else $error("ack late");
	a_ackPulse: assert property (p_ackPulse) else $error("ack too long");
	a_dirReset: assert property (p_dirReset) else $error("direction not cleared");
	a_dirWrite: assert property (p_dirWrite) else $error("enable not from direction");
	a_latchWrite: assert property (p_latchWrite) else $error("latch write lost");
	a_readUpper: assert property (p_readUpper) else $error("upper bits set");
	a_unimplRead: assert property (p_unimplRead) else $error("hole reads nonzero");
	a_thirdUpper: assert property (p_thirdUpper) else $error("third upper set");
	a_outRead: assert property (p_outRead) else $error("output bit not latch");
	a_faultOne: assert property (p_faultOne) else $error("fault one connected");
	a_faultFour: assert property (p_faultFour) else $error("fault four connected");
	c_write: cover property (wrAck);
	c_read: cover property (rdAck);
	c_faultOff: cover property (thirdPinOe[0] [*2]);
endmodule : tpio_top_monitor

bind tpio_top tpio_top_monitor #(.ADR_W(ADR_W)) i_mon (.clk(clk), .rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.firstPinOut(firstPinOut), .firstPinOe(firstPinOe), .secondPinOe(secondPinOe),
	.thirdPinOe(thirdPinOe), .motorFaultInputOne(motorFaultInputOne),
	.motorFaultInputFour(motorFaultInputFour));

// *** rtl/tpio_pkg.sv ***
// constants shared by the three-port parallel io block
package tpio_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int SEL_W = 4;
	localparam int ADR_LSB = 2;
	localparam int IDX_W = 3;
	localparam int REG_W = 8;

	// ----------------------------------------------------------------
	// port widths
	// ----------------------------------------------------------------
	localparam int FIRST_W = 7;
	localparam int SECOND_W = 7;
	localparam int THIRD_W = 2;

	// ----------------------------------------------------------------
	// register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_FIRST_LATCH = 3'h0;
	localparam logic [IDX_W-1:0] IDX_SECOND_LATCH = 3'h1;
	localparam logic [IDX_W-1:0] IDX_THIRD_LATCH = 3'h2;
	localparam logic [IDX_W-1:0] IDX_UNIMPL = 3'h3;
	localparam logic [IDX_W-1:0] IDX_FIRST_DIR = 3'h4;
	localparam logic [IDX_W-1:0] IDX_SECOND_DIR = 3'h5;
	localparam logic [IDX_W-1:0] IDX_THIRD_DIR = 3'h6;

	// ----------------------------------------------------------------
	// reset and idle values
	// ----------------------------------------------------------------
	localparam logic [FIRST_W-1:0] FIRST_DIR_RST = 7'h00;
	localparam logic [SECOND_W-1:0] SECOND_DIR_RST = 7'h00;
	localparam logic [THIRD_W-1:0] THIRD_DIR_RST = 2'h0;
	localparam logic FAULT_IDLE = 1'b0;
	localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

	// ----------------------------------------------------------------
	// third port bit positions feeding the fault lines
	// ----------------------------------------------------------------
	localparam int FAULT_ONE_BIT = 0;
	localparam int FAULT_FOUR_BIT = 1;

endpackage : tpio_pkg

// *** rtl/tpio_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module tpio_sync #(
	parameter int WIDTH = 7
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// raw pin level and filtered level
	input wire logic [WIDTH-1:0] pinRaw,
	output logic [WIDTH-1:0] pinLevel
);

	// ----------------------------------------------------------------
	// stages
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] stageOne_ff;
	logic [WIDTH-1:0] stageTwo_ff;
	logic [WIDTH-1:0] stageThree_ff;
	logic [WIDTH-1:0] level_ff;
	logic [WIDTH-1:0] nxt_level;

	// a bit only moves once stages two and three agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			if (stageTwo_ff[i] == stageThree_ff[i]) begin
				nxt_level[i] = stageThree_ff[i];
			end else begin
				nxt_level[i] = level_ff[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stageOne_ff <= '0;
			stageTwo_ff <= '0;
			stageThree_ff <= '0;
			level_ff <= '0;
		end else begin
			stageOne_ff <= pinRaw;
			stageTwo_ff <= stageOne_ff;
			stageThree_ff <= stageTwo_ff;
			level_ff <= nxt_level;
		end
	end

	assign pinLevel = level_ff;

endmodule : tpio_sync

// *** rtl/tpio_top.sv ***
// three-port parallel io block with classic wishbone register slave
`timescale 1ns/10ps

module tpio_top #(
	parameter int ADR_W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [tpio_pkg::SEL_W-1:0] wb_sel_i,
	input wire logic [tpio_pkg::DATA_W-1:0] wb_dat_i,
	output logic [tpio_pkg::DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// first port pins
	input wire logic [tpio_pkg::FIRST_W-1:0] firstPinIn,
	output logic [tpio_pkg::FIRST_W-1:0] firstPinOut,
	output logic [tpio_pkg::FIRST_W-1:0] firstPinOe,
	// second port pins
	input wire logic [tpio_pkg::SECOND_W-1:0] secondPinIn,
	output logic [tpio_pkg::SECOND_W-1:0] secondPinOut,
	output logic [tpio_pkg::SECOND_W-1:0] secondPinOe,
	// third port pins
	input wire logic [tpio_pkg::THIRD_W-1:0] thirdPinIn,
	output logic [tpio_pkg::THIRD_W-1:0] thirdPinOut,
	output logic [tpio_pkg::THIRD_W-1:0] thirdPinOe,
	// fault lines toward the motor pwm
	output logic motorFaultInputOne,
	output logic motorFaultInputFour
);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	// true when the word address hits the given index, upper bits zero
	function automatic logic hitIdx(
		input logic [ADR_W-1:0] adr,
		input logic [tpio_pkg::IDX_W-1:0] idx
	);
		logic [ADR_W-1:0] want;
		want = ADR_W'({idx, {tpio_pkg::ADR_LSB{1'b0}}});
		hitIdx = (adr[ADR_W-1:tpio_pkg::ADR_LSB] == want[ADR_W-1:tpio_pkg::ADR_LSB]);
	endfunction : hitIdx

	// per bit: output bits show the latch, input bits show the pin
	function automatic logic [tpio_pkg::REG_W-1:0] mixRead(
		input logic [tpio_pkg::REG_W-1:0] latch,
		input logic [tpio_pkg::REG_W-1:0] dir,
		input logic [tpio_pkg::REG_W-1:0] pin
	);
		mixRead = (dir & latch) | (~dir & pin);
	endfunction : mixRead

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [tpio_pkg::FIRST_W-1:0] firstPortLatch_ff;
	logic [tpio_pkg::SECOND_W-1:0] secondPortLatch_ff;
	logic [tpio_pkg::THIRD_W-1:0] thirdPortLatch_ff;
	logic [tpio_pkg::FIRST_W-1:0] firstPortDirection_ff;
	logic [tpio_pkg::SECOND_W-1:0] secondPortDirection_ff;
	logic [tpio_pkg::THIRD_W-1:0] thirdPortDirection_ff;
	logic [tpio_pkg::FIRST_W-1:0] nxt_firstPortLatch;
	logic [tpio_pkg::SECOND_W-1:0] nxt_secondPortLatch;
	logic [tpio_pkg::THIRD_W-1:0] nxt_thirdPortLatch;
	logic [tpio_pkg::FIRST_W-1:0] nxt_firstPortDirection;
	logic [tpio_pkg::SECOND_W-1:0] nxt_secondPortDirection;
	logic [tpio_pkg::THIRD_W-1:0] nxt_thirdPortDirection;

	logic ack_ff;
	logic nxt_ack;
	logic [tpio_pkg::DATA_W-1:0] rdData_ff;
	logic [tpio_pkg::DATA_W-1:0] nxt_rdData;

	logic faultOne_ff;
	logic faultFour_ff;
	logic nxt_faultOne;
	logic nxt_faultFour;

	logic [tpio_pkg::FIRST_W-1:0] firstPinLevel;
	logic [tpio_pkg::SECOND_W-1:0] secondPinLevel;
	logic [tpio_pkg::THIRD_W-1:0] thirdPinLevel;

	logic busReq;
	logic wrCommit;
	logic [tpio_pkg::REG_W-1:0] wrByte;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	tpio_sync #(
		.WIDTH(tpio_pkg::FIRST_W)
	) u_firstSync (
		.clk(clk),
		.rst_n(rst_n),
		.pinRaw(firstPinIn),
		.pinLevel(firstPinLevel)
	);

	tpio_sync #(
		.WIDTH(tpio_pkg::SECOND_W)
	) u_secondSync (
		.clk(clk),
		.rst_n(rst_n),
		.pinRaw(secondPinIn),
		.pinLevel(secondPinLevel)
	);

	tpio_sync #(
		.WIDTH(tpio_pkg::THIRD_W)
	) u_thirdSync (
		.clk(clk),
		.rst_n(rst_n),
		.pinRaw(thirdPinIn),
		.pinLevel(thirdPinLevel)
	);

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------
	// ack one cycle after the request, dropped the cycle after
	assign busReq = wb_cyc_i & wb_stb_i;
	// writes land on the edge at which the master sees ack
	assign wrCommit = busReq & wb_we_i & ack_ff & wb_sel_i[0];
	assign wrByte = wb_dat_i[tpio_pkg::REG_W-1:0];

	always_comb begin
		nxt_ack = busReq & ~ack_ff;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= nxt_ack;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always_comb begin
		nxt_rdData = tpio_pkg::READ_ZERO;
		if (busReq & ~ack_ff & ~wb_we_i) begin
			if (hitIdx(wb_adr_i, tpio_pkg::IDX_FIRST_LATCH)) begin
				nxt_rdData = tpio_pkg::DATA_W'(mixRead(
					tpio_pkg::REG_W'(firstPortLatch_ff),
					tpio_pkg::REG_W'(firstPortDirection_ff),
					tpio_pkg::REG_W'(firstPinLevel)));
			end else if (hitIdx(wb_adr_i, tpio_pkg::IDX_SECOND_LATCH)) begin
				nxt_rdData = tpio_pkg::DATA_W'(mixRead(
					tpio_pkg::REG_W'(secondPortLatch_ff),
					tpio_pkg::REG_W'(secondPortDirection_ff),
					tpio_pkg::REG_W'(secondPinLevel)));
			end else if (hitIdx(wb_adr_i, tpio_pkg::IDX_THIRD_LATCH)) begin
				nxt_rdData = tpio_pkg::DATA_W'(mixRead(
					tpio_pkg::REG_W'(thirdPortLatch_ff),
					tpio_pkg::REG_W'(thirdPortDirection_ff),
					tpio_pkg::REG_W'(thirdPinLevel)));
			end else if (hitIdx(wb_adr_i, tpio_pkg::IDX_FIRST_DIR)) begin
				nxt_rdData = tpio_pkg::DATA_W'(firstPortDirection_ff);
			end else if (hitIdx(wb_adr_i, tpio_pkg::IDX_SECOND_DIR)) begin
				nxt_rdData = tpio_pkg::DATA_W'(secondPortDirection_ff);
			end else if (hitIdx(wb_adr_i, tpio_pkg::IDX_THIRD_DIR)) begin
				nxt_rdData = tpio_pkg::DATA_W'(thirdPortDirection_ff);
			end else begin
				nxt_rdData = tpio_pkg::READ_ZERO;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_ff <= tpio_pkg::READ_ZERO;
		end else begin
			rdData_ff <= nxt_rdData;
		end
	end

	// ----------------------------------------------------------------
	// data latches
	// ----------------------------------------------------------------
	// written whatever the direction; the pin readback is untouched
	always_comb begin
		nxt_firstPortLatch = firstPortLatch_ff;
		nxt_secondPortLatch = secondPortLatch_ff;
		nxt_thirdPortLatch = thirdPortLatch_ff;
		if (wrCommit && hitIdx(wb_adr_i, tpio_pkg::IDX_FIRST_LATCH)) begin
			nxt_firstPortLatch = wrByte[tpio_pkg::FIRST_W-1:0];
		end
		if (wrCommit && hitIdx(wb_adr_i, tpio_pkg::IDX_SECOND_LATCH)) begin
			nxt_secondPortLatch = wrByte[tpio_pkg::SECOND_W-1:0];
		end
		if (wrCommit && hitIdx(wb_adr_i, tpio_pkg::IDX_THIRD_LATCH)) begin
			nxt_thirdPortLatch = wrByte[tpio_pkg::THIRD_W-1:0];
		end
	end

	// no reset on purpose: latch contents survive a reset
	always_ff @(posedge clk) begin
		firstPortLatch_ff <= nxt_firstPortLatch;
		secondPortLatch_ff <= nxt_secondPortLatch;
		thirdPortLatch_ff <= nxt_thirdPortLatch;
	end

	// ----------------------------------------------------------------
	// direction registers
	// ----------------------------------------------------------------
	always_comb begin
		nxt_firstPortDirection = firstPortDirection_ff;
		nxt_secondPortDirection = secondPortDirection_ff;
		nxt_thirdPortDirection = thirdPortDirection_ff;
		if (wrCommit && hitIdx(wb_adr_i, tpio_pkg::IDX_FIRST_DIR)) begin
			nxt_firstPortDirection = wrByte[tpio_pkg::FIRST_W-1:0];
		end
		if (wrCommit && hitIdx(wb_adr_i, tpio_pkg::IDX_SECOND_DIR)) begin
			nxt_secondPortDirection = wrByte[tpio_pkg::SECOND_W-1:0];
		end
		if (wrCommit && hitIdx(wb_adr_i, tpio_pkg::IDX_THIRD_DIR)) begin
			nxt_thirdPortDirection = wrByte[tpio_pkg::THIRD_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			firstPortDirection_ff <= tpio_pkg::FIRST_DIR_RST;
			secondPortDirection_ff <= tpio_pkg::SECOND_DIR_RST;
			thirdPortDirection_ff <= tpio_pkg::THIRD_DIR_RST;
		end else begin
			firstPortDirection_ff <= nxt_firstPortDirection;
			secondPortDirection_ff <= nxt_secondPortDirection;
			thirdPortDirection_ff <= nxt_thirdPortDirection;
		end
	end

	// ----------------------------------------------------------------
	// fault mirror on the third port
	// ----------------------------------------------------------------
	// an output pin no longer feeds the pwm, which sees no fault
	always_comb begin
		nxt_faultOne = thirdPinLevel[tpio_pkg::FAULT_ONE_BIT];
		nxt_faultFour = thirdPinLevel[tpio_pkg::FAULT_FOUR_BIT];
		if (thirdPortDirection_ff[tpio_pkg::FAULT_ONE_BIT]) begin
			nxt_faultOne = tpio_pkg::FAULT_IDLE;
		end
		if (thirdPortDirection_ff[tpio_pkg::FAULT_FOUR_BIT]) begin
			nxt_faultFour = tpio_pkg::FAULT_IDLE;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			faultOne_ff <= tpio_pkg::FAULT_IDLE;
			faultFour_ff <= tpio_pkg::FAULT_IDLE;
		end else begin
			faultOne_ff <= nxt_faultOne;
			faultFour_ff <= nxt_faultFour;
		end
	end

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	// pins are driven straight from the latch and direction flops
	genvar gi;
	generate
		for (gi = 0; gi < tpio_pkg::FIRST_W; gi++) begin : g_first
			assign firstPinOut[gi] = firstPortLatch_ff[gi];
			assign firstPinOe[gi] = firstPortDirection_ff[gi];
		end
		for (gi = 0; gi < tpio_pkg::SECOND_W; gi++) begin : g_second
			assign secondPinOut[gi] = secondPortLatch_ff[gi];
			assign secondPinOe[gi] = secondPortDirection_ff[gi];
		end
		for (gi = 0; gi < tpio_pkg::THIRD_W; gi++) begin : g_third
			assign thirdPinOut[gi] = thirdPortLatch_ff[gi];
			assign thirdPinOe[gi] = thirdPortDirection_ff[gi];
		end
	endgenerate

	// ----------------------------------------------------------------
	// remaining outputs
	// ----------------------------------------------------------------
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdData_ff;
	assign motorFaultInputOne = faultOne_ff;
	assign motorFaultInputFour = faultFour_ff;

endmodule : tpio_top
